// ---- hw/crrs_cfg.svh ----
// constants for the return, rotate, subtract and sleep executor
`ifndef CRRS_CFG_SVH
`define CRRS_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CRRS_OFS_INSTR 12'h000
`define CRRS_OFS_WREG 12'h004
`define CRRS_OFS_STATUS 12'h008
`define CRRS_OFS_PC 12'h00C
`define CRRS_OFS_STACK 12'h010
`define CRRS_OFS_FADDR 12'h014
`define CRRS_OFS_FDATA 12'h018
`define CRRS_OFS_WDOG 12'h01C
`define CRRS_OFS_CTRL 12'h020

// ****************************************
// field positions
// ****************************************
`define CRRS_INSTR_OP_MSB 15
`define CRRS_INSTR_OP_LSB 12
`define CRRS_INSTR_DEST_BIT 8
`define CRRS_STAT_BUSY_BIT 8
`define CRRS_STAT_SLEEP_BIT 9
`define CRRS_STACK_DEPTH_LSB 16
`define CRRS_CTRL_WAKE_BIT 0

// ****************************************
// reset values
// ****************************************
`define CRRS_RST_BYTE 8'h00
`define CRRS_RST_FLAG 1'b0
`define CRRS_RST_NFLAG 1'b1
`define CRRS_RST_INSTR 16'h0000

// ****************************************
// timing counts, in clocks and instruction cycles
// ****************************************
`define CRRS_CLKS_PER_CYC 4
`define CRRS_CYC_SINGLE 1
`define CRRS_CYC_RETURN 2

`endif

// ---- hw/crrs_pkg.sv ----
// types shared by the executor and its arithmetic unit
package crrs_pkg;

  // ****************************************
  // operation codes held in the instruction register
  // ****************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_RETURN = 4'h1,
    OP_ROTL = 4'h2,
    OP_ROTR = 4'h3,
    OP_SUBLIT = 4'h4,
    OP_SUBFILE = 4'h5,
    OP_SLEEP = 4'h6
  } crrs_op_t;

  // ****************************************
  // executor states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_SLEEP = 2'b10
  } crrs_state_t;

  // status flags, power flags active low
  typedef struct packed {
    logic timeout_status_bit;
    logic powerdown_status_bit;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } crrs_status_t;

  // arithmetic result with its flags
  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic digit_carry;
    logic zero;
  } crrs_alu_res_t;

endpackage : crrs_pkg

// ---- hw/crrs_alu.sv ----
// rotate and subtract datapath
`timescale 1ns/100ps
module crrs_alu
  import crrs_pkg::*;
(
  input wire crrs_op_t op,
  input wire logic [7:0] file_val,
  input wire logic [7:0] w_val,
  input wire logic [7:0] lit_val,
  input wire logic carry_in,
  output crrs_alu_res_t res
);

  logic [8:0] diff; // minuend minus w, bit 8 is the borrow
  logic [4:0] ndiff; // low nibble difference
  logic [7:0] minuend; // literal or file operand

  // ****************************************
  // combinational datapath
  // ****************************************
  always_comb begin
    minuend = (op == OP_SUBLIT) ? lit_val : file_val;
    diff = {1'b0, minuend} - {1'b0, w_val};
    ndiff = {1'b0, minuend[3:0]} - {1'b0, w_val[3:0]};
    res.result = file_val;
    res.carry = carry_in;
    res.digit_carry = 1'b0;
    res.zero = 1'b0;
    case (op)
      // msb to carry, carry to lsb
      OP_ROTL: begin
        res.result = {file_val[6:0], carry_in};
        res.carry = file_val[7];
      end
      // lsb to carry, carry to msb
      OP_ROTR: begin
        res.result = {carry_in, file_val[7:1]};
        res.carry = file_val[0];
      end
      OP_SUBLIT, OP_SUBFILE: begin
        res.result = diff[7:0];
        // carry means no borrow
        res.carry = ~diff[8];
        res.digit_carry = ~ndiff[4];
        res.zero = (diff[7:0] == 8'h00);
      end
      default: begin
        res.result = file_val;
      end
    endcase
  end

endmodule : crrs_alu

// ---- hw/crrs_core.sv ----
// executor for return, rotate, subtract, sleep and no-op with an apb register port
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "crrs_cfg.svh"
module crrs_core
  import crrs_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int STACK_DEPTH = 8,
  parameter int FILE_DEPTH = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_req,
  output logic osc_halt
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int FA_W = $clog2(FILE_DEPTH);
  localparam int CNT_W = 4;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (PC_W < 8 || PC_W > 16) begin : g_bad_pc
    $error("crrs_core: PC_W must lie in 8..16");
  end
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_stack
    $error("crrs_core: STACK_DEPTH must be a power of two");
  end
  if (FILE_DEPTH < 2 || FILE_DEPTH > 128 || (1 << FA_W) != FILE_DEPTH) begin : g_bad_file
    $error("crrs_core: FILE_DEPTH must be a power of two up to 128");
  end

  // ****************************************
  // state
  // ****************************************
  crrs_state_t state_ff, nxt_state; // executor state
  logic [CNT_W-1:0] cnt_ff, nxt_cnt; // clocks left in instruction
  logic [15:0] instr_ff, nxt_instr; // last issued instruction
  logic [7:0] w_ff, nxt_w; // working register
  crrs_status_t stat_ff, nxt_stat; // arithmetic and power flags
  logic [PC_W-1:0] pc_ff, nxt_pc; // program counter
  logic [SP_W-1:0] sp_ff, nxt_sp; // next free stack slot
  logic [SP_W:0] depth_ff, nxt_depth; // entries held, saturating
  logic [FA_W-1:0] faddr_ff, nxt_faddr; // file pointer for software
  logic [7:0] wdog_ff, nxt_wdog; // watchdog_counter
  logic [7:0] presc_ff, nxt_presc; // watchdog prescaler
  logic [31:0] rdata_ff, nxt_rdata; // read data captured in setup
  logic [PC_W-1:0] stack_mem [STACK_DEPTH]; // hardware stack
  logic [7:0] file_mem [FILE_DEPTH]; // file registers

  // memory write ports
  logic stk_we; // stack push from software
  logic [PC_W-1:0] stk_wdata; // pushed return address
  logic fm_we; // file register write
  logic [FA_W-1:0] fm_waddr; // file register address
  logic [7:0] fm_wdata; // file register data

  // ****************************************
  // decode of bus and instruction
  // ****************************************
  logic wr_acc; // write access completes this edge
  logic rd_setup; // read setup phase, capture data
  logic addr_ok; // address maps to a register
  crrs_op_t cur_op; // op field of written instruction
  logic dest_file; // destination select bit
  logic [FA_W-1:0] op_faddr; // file operand address
  logic [7:0] op_lit; // literal operand
  logic [7:0] op_fval; // file operand value
  logic [PC_W-1:0] stack_top_entry; // value a return will load
  crrs_alu_res_t alu_res; // datapath result
  logic issue; // instruction accepted this edge

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign cur_op = crrs_op_t'(pwdata[`CRRS_INSTR_OP_MSB:`CRRS_INSTR_OP_LSB]);
  assign dest_file = pwdata[`CRRS_INSTR_DEST_BIT];
  assign op_faddr = pwdata[FA_W-1:0];
  assign op_lit = pwdata[7:0];
  assign op_fval = file_mem[op_faddr];
  assign stack_top_entry = stack_mem[sp_ff - SP_W'(1)];
  // instructions are taken only while idle; others are dropped
  assign issue = wr_acc && (paddr == `CRRS_OFS_INSTR) && (state_ff == ST_IDLE);

  // address map check
  always_comb begin
    case (paddr)
      `CRRS_OFS_INSTR, `CRRS_OFS_WREG, `CRRS_OFS_STATUS, `CRRS_OFS_PC, `CRRS_OFS_STACK,
      `CRRS_OFS_FADDR, `CRRS_OFS_FDATA, `CRRS_OFS_WDOG, `CRRS_OFS_CTRL: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // zero wait state; error only for unmapped words
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = rdata_ff;
  // oscillator stays stopped for the whole sleep
  assign osc_halt = (state_ff == ST_SLEEP);

  // ****************************************
  // arithmetic unit
  // ****************************************
  crrs_alu crrs_alu_i (
    .op(cur_op),
    .file_val(op_fval),
    .w_val(w_ff),
    .lit_val(op_lit),
    .carry_in(stat_ff.carry_flag),
    .res(alu_res)
  );

  // ****************************************
  // next state of executor and registers
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_instr = instr_ff;
    nxt_w = w_ff;
    nxt_stat = stat_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_depth = depth_ff;
    nxt_faddr = faddr_ff;
    stk_we = 1'b0;
    stk_wdata = pwdata[PC_W-1:0];
    fm_we = 1'b0;
    fm_waddr = faddr_ff;
    fm_wdata = pwdata[7:0];
    // watchdog runs free from its prescaler
    nxt_presc = presc_ff + 8'h01;
    nxt_wdog = (presc_ff == 8'hFF) ? wdog_ff + 8'h01 : wdog_ff;

    // countdown of the running instruction
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = cnt_ff;
      end
      ST_BUSY: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      ST_SLEEP: begin
        // wake by pin or by software
        if (wake_req || (wr_acc && paddr == `CRRS_OFS_CTRL && pwdata[`CRRS_CTRL_WAKE_BIT])) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase

    // software writes to plain registers
    if (wr_acc) begin
      case (paddr)
        `CRRS_OFS_WREG: begin
          nxt_w = pwdata[7:0];
        end
        `CRRS_OFS_STATUS: begin
          // power flags are read only
          nxt_stat.carry_flag = pwdata[0];
          nxt_stat.digit_carry_flag = pwdata[1];
          nxt_stat.zero_flag = pwdata[2];
        end
        `CRRS_OFS_PC: begin
          nxt_pc = pwdata[PC_W-1:0];
        end
        `CRRS_OFS_STACK: begin
          // push wraps over the oldest entry when full
          stk_we = 1'b1;
          nxt_sp = sp_ff + SP_W'(1);
          if (depth_ff != (SP_W+1)'(STACK_DEPTH)) begin
            nxt_depth = depth_ff + (SP_W+1)'(1);
          end
        end
        `CRRS_OFS_FADDR: begin
          nxt_faddr = pwdata[FA_W-1:0];
        end
        `CRRS_OFS_FDATA: begin
          fm_we = 1'b1;
        end
        default: begin
          nxt_faddr = faddr_ff;
        end
      endcase
    end

    // execution of an accepted instruction
    if (issue) begin
      nxt_instr = pwdata[15:0];
      nxt_state = ST_BUSY;
      nxt_cnt = CNT_W'(`CRRS_CYC_SINGLE * `CRRS_CLKS_PER_CYC - 1);
      nxt_pc = pc_ff + PC_W'(1);
      case (cur_op)
        OP_RETURN: begin
          nxt_pc = stack_top_entry;
          nxt_sp = sp_ff - SP_W'(1);
          if (depth_ff != '0) begin
            nxt_depth = depth_ff - (SP_W+1)'(1);
          end
          nxt_cnt = CNT_W'(`CRRS_CYC_RETURN * `CRRS_CLKS_PER_CYC - 1);
        end
        OP_ROTL, OP_ROTR, OP_SUBFILE: begin
          if (dest_file) begin
            fm_we = 1'b1;
            fm_waddr = op_faddr;
            fm_wdata = alu_res.result;
          end else begin
            nxt_w = alu_res.result;
          end
          nxt_stat.carry_flag = alu_res.carry;
          if (cur_op == OP_SUBFILE) begin
            nxt_stat.digit_carry_flag = alu_res.digit_carry;
            nxt_stat.zero_flag = alu_res.zero;
          end
        end
        OP_SUBLIT: begin
          nxt_w = alu_res.result;
          nxt_stat.carry_flag = alu_res.carry;
          nxt_stat.digit_carry_flag = alu_res.digit_carry;
          nxt_stat.zero_flag = alu_res.zero;
        end
        OP_SLEEP: begin
          nxt_stat.powerdown_status_bit = 1'b0;
          nxt_stat.timeout_status_bit = 1'b1;
          nxt_wdog = `CRRS_RST_BYTE;
          nxt_presc = `CRRS_RST_BYTE;
          nxt_state = ST_SLEEP;
        end
        default: begin
          nxt_cnt = CNT_W'(`CRRS_CYC_SINGLE * `CRRS_CLKS_PER_CYC - 1);
        end
      endcase
    end

    // read data is captured in the setup phase
    nxt_rdata = rdata_ff;
    if (rd_setup) begin
      nxt_rdata = 32'h0000_0000;
      case (paddr)
        `CRRS_OFS_INSTR: nxt_rdata[15:0] = instr_ff;
        `CRRS_OFS_WREG: nxt_rdata[7:0] = w_ff;
        `CRRS_OFS_STATUS: begin
          nxt_rdata[4:0] = {stat_ff.timeout_status_bit, stat_ff.powerdown_status_bit,
                            stat_ff.zero_flag, stat_ff.digit_carry_flag, stat_ff.carry_flag};
          nxt_rdata[`CRRS_STAT_BUSY_BIT] = (state_ff == ST_BUSY);
          nxt_rdata[`CRRS_STAT_SLEEP_BIT] = (state_ff == ST_SLEEP);
        end
        `CRRS_OFS_PC: nxt_rdata[PC_W-1:0] = pc_ff;
        `CRRS_OFS_STACK: begin
          nxt_rdata[PC_W-1:0] = stack_top_entry;
          nxt_rdata[`CRRS_STACK_DEPTH_LSB +: SP_W+1] = depth_ff;
        end
        `CRRS_OFS_FADDR: nxt_rdata[FA_W-1:0] = faddr_ff;
        `CRRS_OFS_FDATA: nxt_rdata[7:0] = file_mem[faddr_ff];
        `CRRS_OFS_WDOG: nxt_rdata[15:0] = {presc_ff, wdog_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      instr_ff <= `CRRS_RST_INSTR;
      w_ff <= `CRRS_RST_BYTE;
      stat_ff.carry_flag <= `CRRS_RST_FLAG;
      stat_ff.digit_carry_flag <= `CRRS_RST_FLAG;
      stat_ff.zero_flag <= `CRRS_RST_FLAG;
      stat_ff.powerdown_status_bit <= `CRRS_RST_NFLAG;
      stat_ff.timeout_status_bit <= `CRRS_RST_NFLAG;
      pc_ff <= '0;
      sp_ff <= '0;
      depth_ff <= '0;
      faddr_ff <= '0;
      wdog_ff <= `CRRS_RST_BYTE;
      presc_ff <= `CRRS_RST_BYTE;
      rdata_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      instr_ff <= nxt_instr;
      w_ff <= nxt_w;
      stat_ff <= nxt_stat;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      depth_ff <= nxt_depth;
      faddr_ff <= nxt_faddr;
      wdog_ff <= nxt_wdog;
      presc_ff <= nxt_presc;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // stack and file storage, data only, no reset
  // ****************************************
  always_ff @(posedge pclk) begin
    if (stk_we) begin
      stack_mem[sp_ff] <= stk_wdata;
    end
    if (fm_we) begin
      file_mem[fm_waddr] <= fm_wdata;
    end
  end

endmodule : crrs_core

// ---- verif/crrs_core_asserts.sv ----
// port checker for the return, rotate, subtract and sleep executor
`timescale 1ns/100ps
module crrs_core_asserts
  import crrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wake_req,
  input wire logic osc_halt
);
  // ****************************************
  // helper model of busy time and sleep age
  // ****************************************
  logic wr_acc;
  logic rd_st;
  logic go;
  logic wake_wr;
  logic [3:0] busy_ff, nxt_busy;
  logic [8:0] since_ff, nxt_since;
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_st = psel & penable & !pwrite & pready & (paddr == 12'h008);
  // instruction taken only when idle and awake
  assign go = wr_acc & (paddr == 12'h000) & (busy_ff == 4'h0) & !osc_halt;
  assign wake_wr = wr_acc & (paddr == 12'h020) & pwdata[0];
  // next busy count and clocks since sleep entry
  always_comb begin
    nxt_busy = (busy_ff == 4'h0) ? 4'h0 : busy_ff - 4'h1;
    nxt_since = (since_ff == 9'h1FF) ? since_ff : since_ff + 9'h001;
    if (go) begin
      // return holds two cycles, sleep none
      nxt_busy = (pwdata[15:12] == OP_RETURN) ? 4'h8 : (pwdata[15:12] == OP_SLEEP) ? 4'h0 : 4'h4;
      if (pwdata[15:12] == OP_SLEEP) begin
        nxt_since = 9'h000;
      end
    end
  end
  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 4'h0;
      since_ff <= 9'h1FF;
    end else begin
      busy_ff <= nxt_busy;
      since_ff <= nxt_since;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // properties
  // ****************************************
  property p_sleep_halts; go && pwdata[15:12] == OP_SLEEP |=> osc_halt; endproperty
  a_sleep_halts: assert property (p_sleep_halts) else $error("no halt after sleep");
  property p_halt_cause; $rose(osc_halt) |-> $past(go && pwdata[15:12] == OP_SLEEP); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without sleep");
  property p_halt_holds; osc_halt && !wake_req && !wake_wr |=> osc_halt; endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("halt dropped alone");
  property p_wake; osc_halt && wake_req |=> !osc_halt; endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_sleep_stat; rd_st && $past(osc_halt) |-> prdata[9] && prdata[4:3] == 2'h2; endproperty
  a_sleep_stat: assert property (p_sleep_stat) else $error("sleep status wrong");
  property p_wdog_zero;
    psel && penable && !pwrite && paddr == 12'h01C && $past(osc_halt) && since_ff < 9'h0C8
      |-> prdata[7:0] == 8'h00;
  endproperty
  a_wdog_zero: assert property (p_wdog_zero) else $error("watchdog not cleared");
  property p_busy_on; rd_st && $past(busy_ff) >= 4'h2 |-> prdata[8]; endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy too short");
  property p_busy_off; rd_st && $past(busy_ff) == 4'h0 && !$past(osc_halt) |-> !prdata[8]; endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy too long");
  c_return: cover property (go && pwdata[15:12] == OP_RETURN);
  c_sleep: cover property (go && pwdata[15:12] == OP_SLEEP);
  c_wake: cover property (osc_halt && wake_req);
endmodule : crrs_core_asserts

bind crrs_core crrs_core_asserts crrs_core_asserts_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wake_req(wake_req), .osc_halt(osc_halt));

// ---- verif/crrs_core_bench.sv ----
// self-checking bench for the executor
`timescale 1ns/100ps
module crrs_core_bench
  import crrs_pkg::*;
;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic wake_req = 1'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_halt;
  logic [31:0] rd;
  logic err_seen;
  int fail_count = 0;
  int samples_checked = 0;
  crrs_core crrs_core_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_req(wake_req), .osc_halt(osc_halt));
  // free-running 100 ns clock
  initial begin
    forever #50 pclk = ~pclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // one apb transfer, held until pready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 10);
    if (n >= 10) begin
      fail_count++;
      finish_test();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    xfer(1'h0, a, 32'h0);
  endtask : rdr
  // issue one instruction, judge its busy time, wait for idle
  task automatic exec(input logic [15:0] ins, input int n);
    wr(12'h000, {16'h0, ins});
    rdr(12'h008);
    check(rd[8], 1'h1);
    rdr(12'h008);
    check(rd[8], n > 4);
    for (int k = 0; k < 10 && rd[8] !== 1'h0; k++) rdr(12'h008);
    if (rd[8] !== 1'h0) begin
      fail_count++;
      finish_test();
    end
  endtask : exec
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rdr(12'h008);
    check(rd, 32'h18);
    rdr(12'h024);
    check({rd[30:0], err_seen}, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_rotate();
    logic [2:0] s;
    logic [7:0] v, r;
    logic nc;
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      v = 8'h96 ^ {s[0], 6'h00, s[1]};
      wr(12'h014, 32'h5);
      wr(12'h018, {24'h0, v});
      wr(12'h004, 32'h3C);
      wr(12'h008, {29'h0, 2'h2, s[1] ^ s[0]});
      r = s[2] ? {s[1] ^ s[0], v[7:1]} : {v[6:0], s[1] ^ s[0]};
      nc = s[2] ? v[0] : v[7];
      exec({s[2] ? OP_ROTR : OP_ROTL, 3'h0, s[1], 8'h05}, 4);
      rdr(12'h004);
      check(rd, s[1] ? 32'h3C : {24'h0, r});
      rdr(12'h018);
      check(rd, {24'h0, s[1] ? r : v});
      rdr(12'h008);
      check(rd & 32'h7, {29'h0, 2'h2, nc});
    end
    $display("rotate test done");
  endtask : t_rotate
  task automatic t_sub();
    logic [7:0] av [4] = '{8'h10, 8'h05, 8'h20, 8'hFF};
    logic [7:0] wv [4] = '{8'h10, 8'h10, 8'h01, 8'hFE};
    logic [7:0] a, w, r;
    for (int j = 0; j < 12; j++) begin
      a = av[j / 3];
      w = wv[j / 3];
      r = a - w;
      wr(12'h014, 32'h7);
      wr(12'h018, {24'h0, a});
      wr(12'h004, {24'h0, w});
      wr(12'h008, 32'h0);
      exec((j % 3 == 0) ? {OP_SUBLIT, 4'h0, a} : {OP_SUBFILE, 3'h0, j % 3 == 2, 8'h07}, 4);
      rdr(12'h004);
      check(rd, {24'h0, (j % 3 == 2) ? w : r});
      rdr(12'h018);
      check(rd, {24'h0, (j % 3 == 2) ? r : a});
      rdr(12'h008);
      check(rd & 32'h7, {29'h0, r == 8'h00, a[3:0] >= w[3:0], a >= w});
    end
    $display("subtract test done");
  endtask : t_sub
  task automatic t_return();
    wr(12'h010, 32'h123);
    wr(12'h010, 32'h456);
    wr(12'h00C, 32'h10);
    wr(12'h008, 32'h5);
    exec({OP_RETURN, 12'h000}, 8);
    rdr(12'h00C);
    check(rd, 32'h456);
    rdr(12'h010);
    check(rd, 32'h10123);
    rdr(12'h008);
    check(rd & 32'h7, 32'h5);
    $display("return test done");
  endtask : t_return
  task automatic t_nop();
    wr(12'h00C, 32'h1FFE);
    wr(12'h004, 32'h5A);
    wr(12'h008, 32'h3);
    exec({OP_NOP, 12'h0FF}, 4);
    rdr(12'h00C);
    check(rd, 32'h1FFF);
    rdr(12'h004);
    check(rd, 32'h5A);
    rdr(12'h008);
    check(rd & 32'h31F, 32'h1B);
    $display("nop test done");
  endtask : t_nop
  task automatic t_sleep();
    logic [31:0] p;
    repeat (260) @(posedge pclk);
    rdr(12'h01C);
    check(rd[7:0] != 8'h00, 1'h1);
    wr(12'h000, {16'h0000, OP_SLEEP, 12'h000});
    rdr(12'h01C);
    check(rd[7:0], 8'h00);
    check(rd[15:8] < 8'h10, 1'h1);
    rdr(12'h008);
    check(rd & 32'h218, 32'h210);
    check(osc_halt, 1'h1);
    // instructions are ignored while halted
    rdr(12'h00C);
    p = rd;
    wr(12'h000, {16'h0000, OP_NOP, 12'h000});
    rdr(12'h00C);
    check(rd, p);
    @(posedge pclk);
    wake_req <= 1'h1;
    @(posedge pclk);
    wake_req <= 1'h0;
    repeat (2) @(posedge pclk);
    check(osc_halt, 1'h0);
    rdr(12'h008);
    check(rd & 32'h218, 32'h10);
    wr(12'h000, {16'h0000, OP_SLEEP, 12'h000});
    wr(12'h020, 32'h1);
    rdr(12'h008);
    check(rd[9], 1'h0);
    $display("sleep test done");
  endtask : t_sleep
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_rotate();
    t_sub();
    t_return();
    t_nop();
    t_sleep();
    finish_test();
  end
endmodule : crrs_core_bench
